// [logic/gpp_pkg.sv]
package gpp_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_PIN_DATA = 8'h00;
   localparam logic [7:0] ADDR_OUTPUT_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_FUNCTION_SELECT = 8'h08;
   localparam logic [7:0] ADDR_INPUT_ENABLE = 8'h0C;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NPINS = 8;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_PIN_DATA = 8'h00;
   localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h02;
   localparam logic [7:0] RST_FUNCTION_SELECT = 8'h00;
   localparam logic [7:0] RST_INPUT_ENABLE = 8'h03;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int FILTER_NS = 30;
   // Longest time: round down, at least one cycle
   localparam int FILTER_CYC = (FILTER_NS / CLK_PERIOD_NS) < 1 ? 1 :
                               (FILTER_NS / CLK_PERIOD_NS);
   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADDR_W-1:0] adr;
      logic [DATA_W-1:0] dat;
   } gpp_wb_req_t;
   typedef struct packed {
      logic [NPINS-1:0] out;
      logic [NPINS-1:0] oe;
   } gpp_pin_drive_t;
endpackage

// [logic/gpp_filter.sv]
`timescale 1ns/1ps
module gpp_filter #(
   parameter int COUNT = gpp_pkg::FILTER_CYC
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic enable_i,
   // Level
   input wire logic d_i,
   output logic q_o
);
   import gpp_pkg::*;
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] CMAX = CW'(COUNT);
   logic [CW-1:0] cnt;
   // Pulses shorter than COUNT+1 cycles never reach the output
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         q_o <= 1'b0;
         cnt <= '0;
      end else if (ce_i) begin
         if (!enable_i || d_i == q_o) begin
            cnt <= '0;
            if (!enable_i) begin
               q_o <= d_i;
            end
         end else if (cnt == CMAX) begin
            q_o <= d_i;
            cnt <= '0;
         end else begin
            cnt <= cnt + CW'(1);
         end
      end
   end
endmodule

// [logic/gpp_port.sv]
// Functional notes
// - Each pin serves as port I/O or as an assigned peripheral line.
// - Filtered pins reject input pulses shorter than about 30 ns.
// - Every register is a 32-bit word on the bus.
// - Storage exists only for implemented pins.
// - Data register: bits 7-0 read/write, bits 31-8 read zero.
// - Output-enable bits 7-0: one drives the pin, zero disables.
// - Input path is governed by input-enable, not output-enable.
// - Input-enable bits 7-0: one enables the input buffer.
// - Function-select bit set routes pin to peripheral; one per pin.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module gpp_port #(
   parameter int PINS = gpp_pkg::NPINS,
   parameter logic [7:0] FILTER_MASK = 8'h00
) (
   // Clock, reset, enable
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic CE_I,
   // Wishbone slave
   input wire gpp_pkg::gpp_wb_req_t WB_REQ_I,
   output logic [gpp_pkg::DATA_W-1:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic WB_ERR_O,
   // Pins
   input wire logic [PINS-1:0] PIN_I,
   output logic [PINS-1:0] PIN_O,
   output logic [PINS-1:0] PIN_OE_O,
   output logic [PINS-1:0] PIN_IE_O,
   // Peripheral functions
   input wire gpp_pkg::gpp_pin_drive_t FUNC_DRIVE_I,
   output logic [PINS-1:0] FUNC_IN_O,
   output logic [PINS-1:0] FUNC_SEL_O
);
   import gpp_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic [PINS-1:0] pin_data_bits;
   logic [PINS-1:0] pin_output_enable_bits;
   logic [PINS-1:0] port_function_select;
   logic [PINS-1:0] port_input_enable;
   logic [PINS-1:0] sync1;
   logic [PINS-1:0] sync2;
   logic [PINS-1:0] pin_level;
   logic [PINS-1:0] sampled;
   logic [DATA_W-1:0] next_rdata;
   logic req;
   logic wr;
   logic mapped;
   logic [3:0] hit;
   logic wr_pin_data;
   logic wr_output_enable;
   logic wr_function_select;
   logic wr_input_enable;

   // One-hot offset decode: data, output enable, function, input enable
   function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
      decode = {a == ADDR_INPUT_ENABLE, a == ADDR_FUNCTION_SELECT,
                a == ADDR_OUTPUT_ENABLE, a == ADDR_PIN_DATA};
   endfunction

   function automatic logic known(input logic [ADDR_W-1:0] a);
      known = |decode(a);
   endfunction

   function automatic logic [PINS-1:0] merge(input logic [PINS-1:0] old,
         input logic [DATA_W-1:0] d, input logic lane0);
      merge = lane0 ? d[PINS-1:0] : old;
   endfunction

   // ****************************************
   // Bus slave
   // ****************************************
   assign req = WB_REQ_I.cyc && WB_REQ_I.stb && !WB_ACK_O && !WB_ERR_O;
   assign mapped = known(WB_REQ_I.adr);
   assign wr = req && WB_REQ_I.we && mapped;

   // One wait-free answer per request; unmapped offsets answer with err
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         WB_ACK_O <= 1'b0;
         WB_ERR_O <= 1'b0;
      end else if (CE_I) begin
         WB_ACK_O <= req && mapped;
         WB_ERR_O <= req && !mapped;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Data reads return the pin level, not the output latch
   always_comb begin
      next_rdata = '0;
      case (WB_REQ_I.adr)
         ADDR_PIN_DATA: next_rdata[PINS-1:0] = sampled;
         ADDR_OUTPUT_ENABLE: next_rdata[PINS-1:0] = pin_output_enable_bits;
         ADDR_FUNCTION_SELECT: next_rdata[PINS-1:0] = port_function_select;
         ADDR_INPUT_ENABLE: next_rdata[PINS-1:0] = port_input_enable;
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         WB_DAT_O <= '0;
      end else if (CE_I && req) begin
         WB_DAT_O <= next_rdata;
      end
   end

   // ****************************************
   // Write strobes
   // ****************************************
   // A write to an unmapped offset raises no strobe and stores nothing
   assign hit = decode(WB_REQ_I.adr);
   assign wr_pin_data = wr && hit[0];
   assign wr_output_enable = wr && hit[1];
   assign wr_function_select = wr && hit[2];
   assign wr_input_enable = wr && hit[3];

   // Writes honour byte lane 0 only; lanes 1-3 hold no storage
   // Only PINS bits of storage per register
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         pin_data_bits <= RST_PIN_DATA[PINS-1:0];
      end else if (CE_I && wr_pin_data) begin
         pin_data_bits <= merge(pin_data_bits, WB_REQ_I.dat,
                                WB_REQ_I.sel[0]);
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         pin_output_enable_bits <= RST_OUTPUT_ENABLE[PINS-1:0];
      end else if (CE_I && wr_output_enable) begin
         pin_output_enable_bits <= merge(pin_output_enable_bits,
               WB_REQ_I.dat, WB_REQ_I.sel[0]);
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         port_function_select <= RST_FUNCTION_SELECT[PINS-1:0];
      end else if (CE_I && wr_function_select) begin
         port_function_select <= merge(port_function_select,
               WB_REQ_I.dat, WB_REQ_I.sel[0]);
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         port_input_enable <= RST_INPUT_ENABLE[PINS-1:0];
      end else if (CE_I && wr_input_enable) begin
         port_input_enable <= merge(port_input_enable,
               WB_REQ_I.dat, WB_REQ_I.sel[0]);
      end
   end

   // ****************************************
   // Pin input path
   // ****************************************
   // Pins are asynchronous; two stages before anything looks at them
   // Limitation: a pin pulse shorter than one clock may be missed
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         sync1 <= '0;
         sync2 <= '0;
      end else if (CE_I) begin
         sync1 <= PIN_I;
         sync2 <= sync1;
      end
   end

   generate
      for (genvar i = 0; i < PINS; i++) begin : g_pin
         // Input off: the filter tracks the pin, no stale level on enable
         if (FILTER_MASK[i]) begin : g_filt
            gpp_filter #(
               .COUNT(FILTER_CYC)
            ) u_filter (
               .clk_i(MCLK_I),
               .rstn_i(RSTN_I),
               .ce_i(CE_I),
               .enable_i(port_input_enable[i]),
               .d_i(sync2[i]),
               .q_o(pin_level[i])
            );
         end else begin : g_raw
            assign pin_level[i] = sync2[i];
         end
      end
   endgenerate

   // Disabled input reads zero; the output-enable plays no part
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         sampled[i] = port_input_enable[i] ? pin_level[i] : 1'b0;
      end
   end

   // ****************************************
   // Pin drive and peripheral routing
   // ****************************************
   // Drive muxing is combinational from the register flops and FUNC_DRIVE_I; glitch-free per select
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (port_function_select[i]) begin
            PIN_O[i] = FUNC_DRIVE_I.out[i];
            PIN_OE_O[i] = FUNC_DRIVE_I.oe[i];
         end else begin
            PIN_O[i] = pin_data_bits[i];
            PIN_OE_O[i] = pin_output_enable_bits[i];
         end
      end
   end

   // Peripherals see the same filtered, gated level as software
   assign PIN_IE_O = port_input_enable;
   assign FUNC_IN_O = sampled & port_function_select;
   assign FUNC_SEL_O = port_function_select;
endmodule

// [testbench/gpp_sva.sv]
`timescale 1ns/1ps
module gpp_sva (
   // Watched ports
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire gpp_pkg::gpp_wb_req_t WB_REQ_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic WB_ERR_O,
   input wire logic [7:0] PIN_O,
   input wire logic [7:0] PIN_OE_O,
   input wire logic [7:0] PIN_IE_O,
   input wire gpp_pkg::gpp_pin_drive_t FUNC_DRIVE_I,
   input wire logic [7:0] FUNC_IN_O,
   input wire logic [7:0] FUNC_SEL_O
);
   import gpp_pkg::*;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack too long");
   a_err_pulse: assert property (WB_ERR_O |=> !WB_ERR_O)
      else $error("err too long");
   a_ack_cause: assert property (
      $rose(WB_ACK_O) |-> $past(WB_REQ_I.stb))
      else $error("ack without request");
   a_upper_zero: assert property (
      WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
      else $error("upper bits set");
   a_err_quiet: assert property (
      WB_ERR_O |-> !WB_ACK_O && WB_DAT_O == 32'h0)
      else $error("err with data");
   a_func_oe: assert property (
      (PIN_OE_O & FUNC_SEL_O) == (FUNC_DRIVE_I.oe & FUNC_SEL_O))
      else $error("function enable lost");
   a_func_out: assert property (
      ((PIN_O ^ FUNC_DRIVE_I.out) & FUNC_SEL_O & FUNC_DRIVE_I.oe) == 8'h0)
      else $error("function data lost");
   a_in_gated: assert property (
      (FUNC_IN_O & ~PIN_IE_O) == 8'h0)
      else $error("input not gated");
   a_fin_sel: assert property (
      (FUNC_IN_O & ~FUNC_SEL_O) == 8'h0)
      else $error("function input not routed");
   a_cfg_on_ack: assert property (
      (!$stable(FUNC_SEL_O) || !$stable(PIN_IE_O)) |-> WB_ACK_O)
      else $error("config changed without ack");
endmodule
bind gpp_port gpp_sva i_sva (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
   .WB_REQ_I(WB_REQ_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .WB_ERR_O(WB_ERR_O), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O),
   .PIN_IE_O(PIN_IE_O), .FUNC_DRIVE_I(FUNC_DRIVE_I),
   .FUNC_IN_O(FUNC_IN_O), .FUNC_SEL_O(FUNC_SEL_O));

// [testbench/gpp_pins.sv]
`timescale 1ns/1ps
module gpp_pins (
   // Port side
   input wire logic [7:0] drv_i,
   input wire logic [7:0] oe_i,
   // Board side
   input wire logic [7:0] ext_i,
   output logic [7:0] lvl_o
);
   // A driven pin beats the board; released pins follow the board
   assign lvl_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
   import gpp_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] w;
      logic [7:0] e;
      logic r;
   } gpp_row_t;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   gpp_wb_req_t req = '0;
   gpp_pin_drive_t fdrv = '0;
   logic [7:0] ext = 8'h00;
   logic [31:0] dat, rd;
   logic ack, err, er;
   logic [7:0] pin_i, pin_o, pin_oe, pin_ie, fin, fsel;
   int n_errors = 0;
   int compares = 0;
   gpp_row_t rows [6] = '{'{8'h04, 32'hFFFFFFFF, 8'hFF, 1'b0},
      '{8'h04, 32'h0000000F, 8'h0F, 1'b0},
      '{8'h0C, 32'hFFFFFF00, 8'h00, 1'b0},
      '{8'h0C, 32'h000000FF, 8'hFF, 1'b0},
      '{8'h08, 32'hFFFFFF00, 8'h00, 1'b0},
      '{8'h10, 32'h000000FF, 8'h00, 1'b1}};
   always #10 clk = ~clk;
   gpp_port #(.FILTER_MASK(8'h80)) i_dut (.MCLK_I(clk), .RSTN_I(rstn),
      .CE_I(ce), .WB_REQ_I(req), .WB_DAT_O(dat), .WB_ACK_O(ack),
      .WB_ERR_O(err), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
      .PIN_IE_O(pin_ie), .FUNC_DRIVE_I(fdrv), .FUNC_IN_O(fin),
      .FUNC_SEL_O(fsel));
   gpp_pins i_pins (.drv_i(pin_o), .oe_i(pin_oe), .ext_i(ext),
      .lvl_o(pin_i));
   // ****
   // Bus and compare tasks
   // ****
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b1, w, 4'hF, a, d};
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (ack !== 1'b1 && err !== 1'b1);
      rd = dat;
      er = err;
      req <= '0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic results();
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #50000;
      n_errors++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rdchk(ADDR_OUTPUT_ENABLE, {24'h0, RST_OUTPUT_ENABLE});
      rdchk(ADDR_FUNCTION_SELECT, {24'h0, RST_FUNCTION_SELECT});
      rdchk(ADDR_INPUT_ENABLE, {24'h0, RST_INPUT_ENABLE});
      rdchk(ADDR_PIN_DATA, {24'h0, RST_PIN_DATA});
      foreach (rows[i]) begin
         wb(1'b1, rows[i].a, rows[i].w);
         chk({31'h0, er}, {31'h0, rows[i].r});
         rdchk(rows[i].a, {24'h0, rows[i].e});
      end
      wb(1'b1, ADDR_PIN_DATA, 32'hFFFFFFA5);
      chk({16'h0, pin_oe, pin_o & pin_oe}, 32'h00000F05);
      ext <= 8'hF0;
      repeat (4) @(posedge clk);
      rdchk(ADDR_PIN_DATA, 32'h000000F5);
      wb(1'b1, ADDR_INPUT_ENABLE, 32'h0000000F);
      rdchk(ADDR_PIN_DATA, 32'h00000005);
      chk({16'h0, pin_ie, pin_oe}, 32'h00000F0F);
      wb(1'b1, ADDR_INPUT_ENABLE, 32'h000000FF);
      // A one-cycle dip on the filtered pin must not show
      ext <= 8'h70;
      @(posedge clk);
      ext <= 8'hF0;
      repeat (4) @(posedge clk);
      rdchk(ADDR_PIN_DATA, 32'h000000F5);
      ext <= 8'h70;
      repeat (6) @(posedge clk);
      rdchk(ADDR_PIN_DATA, 32'h00000075);
      fdrv <= '{8'h00, 8'h01};
      wb(1'b1, ADDR_FUNCTION_SELECT, 32'h00000001);
      chk({16'h0, pin_oe, pin_o & pin_oe}, 32'h00000F04);
      // Peripheral drives pin 0 high; only that pin reaches its input
      fdrv <= '{8'h01, 8'h01};
      repeat (4) @(posedge clk);
      chk({16'h0, fsel, fin}, 32'h00000101);
      // Clock enable low: the input path must hold its last level
      ce <= 1'b0;
      fdrv <= '{8'h00, 8'h01};
      repeat (4) @(posedge clk);
      chk({24'h0, fin}, 32'h00000001);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      chk({24'h0, fin}, 32'h00000000);
      fdrv <= '{8'h00, 8'h00};
      @(posedge clk);
      chk({24'h0, pin_oe}, 32'h0000000E);
      // Reset in mid-run brings every register back to its reset value
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rdchk(ADDR_OUTPUT_ENABLE, {24'h0, RST_OUTPUT_ENABLE});
      rdchk(ADDR_FUNCTION_SELECT, {24'h0, RST_FUNCTION_SELECT});
      rdchk(ADDR_INPUT_ENABLE, {24'h0, RST_INPUT_ENABLE});
      chk({16'h0, pin_oe, pin_o},
          {16'h0, RST_OUTPUT_ENABLE, RST_PIN_DATA});
      results();
   end
endmodule
